//--- hw/tgc_cfg.svh
/*
 Offsets, field positions, reset values for the timer gate control block.
 Assumes inclusion by bare name from tgc_gate and the test bench module.
*/
`ifndef TGC_CFG_SVH
`define TGC_CFG_SVH
`define TGC_OFF_GATE_CTRL 8'h00
`define TGC_OFF_TIMER_CTRL 8'h04
`define TGC_OFF_STATUS 8'h08
`define TGC_BIT_GE 7
`define TGC_BIT_POL 6
`define TGC_BIT_TM 5
`define TGC_BIT_SPM 4
`define TGC_BIT_GO 3
`define TGC_BIT_VAL 2
`define TGC_BIT_SS_HI 1
`define TGC_BIT_SS_LO 0
`define TGC_BIT_ON 0
`define TGC_BIT_GIE 1
`define TGC_BIT_GIF 0
`define TGC_GATE_CTRL_RST 8'h00
`define TGC_SS_PIN 2'b00
`define TGC_SS_PERIOD 2'b01
`define TGC_SS_CMP1 2'b10
`define TGC_SS_CMP2 2'b11
`define TGC_RESP_OKAY 2'b00
`define TGC_RESP_SLVERR 2'b10
`endif

//--- hw/tgc_pkg.sv
/*
 Types shared by the timer gate control block.
 Includes nothing; tgc_cfg.svh is included by the modules that use it.
*/
`default_nettype none
package tgc_pkg;
	typedef struct packed {
		logic gate_pin;
		logic period_timer_match;
		logic comparator_one_out;
		logic comparator_two_sync_out;
	} tgc_src_t;
	typedef struct packed {
		logic gate_enable_bit;
		logic gate_polarity;
		logic gate_toggle_mode;
		logic single_pulse_mode;
		logic [1:0] gate_source_sel;
	} tgc_cfg_t;
	typedef enum logic [2:0] {
		TGC_SP_IDLE = 3'b001,
		TGC_SP_ARMED = 3'b010,
		TGC_SP_PULSE = 3'b100
	} tgc_sp_state_t;
endpackage
`default_nettype wire

//--- hw/tgc_sync.sv
/*
 Two-flop synchroniser bank for the gate sources.
 Assumes asynchronous inputs and one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tgc_sync #(
	parameter int WIDTH = 4
) (
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, active low
	input wire logic [WIDTH-1:0] d_in, // async inputs
	output logic [WIDTH-1:0] q_out // synchronised outputs
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] q_r;
	genvar i;
	// ----------------------------------------
	// per-bit two-flop stage
	// ----------------------------------------
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					meta_r[i] <= 1'b0;
					q_r[i] <= 1'b0;
				end else begin
					meta_r[i] <= d_in[i];
					q_r[i] <= meta_r[i];
				end
			end
		end
	endgenerate
	assign q_out = q_r;
endmodule
`default_nettype wire

//--- hw/tgc_gate.sv
/*
 Timer gate control: source select, polarity, toggle, single pulse,
 gate level and gate event flag, with an AXI4-Lite register slave.
 Assumes gate sources may be asynchronous; counter lives outside.
*/
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
// What this block does
// - timer on and gate enabled: gate qualifies counting
// - gate disabled, timer on: count always
// - polarity bit picks active gate level
// - toggle mode routes gate through toggle flop
// - toggle mode off holds toggle flop cleared
// - toggle flop inverts on gate rising edge
// - single pulse mode controls counting gate
// - go bit set arms acquisition, hardware clears
// - go clear: no further pulses admitted
// - clearing single pulse mode clears go
// - read-only gate level after all processing
// - gate level tracks regardless of enable
// - select 00 takes gate pin
// - select 01 takes period timer match
// - select 10/11 take comparator outputs
// - go clears at trailing edge of pulse
// - gate level falling edge sets event flag
// - timer off stops count, clears gate flop
// - toggle plus single pulse measures period
`timescale 1ns/1ps
`default_nettype none
`include "tgc_cfg.svh"
module tgc_gate (
	input wire logic aclk, // clock, 250 MHz
	input wire logic aresetn, // sync reset, active low
	input wire tgc_pkg::tgc_src_t src_in, // raw gate sources
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic count_enable, // counter may increment
	output logic gate_event_irq // event flag and irq enable
);
	import tgc_pkg::*;
	tgc_cfg_t cfg_r;
	tgc_src_t src_s;
	tgc_sp_state_t sp_r;
	logic timer_on_r, gie_r, gif_r;
	logic go_r, tog_r, tog_d_r, sel_r, sel_d_r, lvl_d_r;
	logic aw_got_r, w_got_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic sel_raw, sel_rise, sel_fall, pol_out, tog_out, gate_level;
	logic lvl_fall, wr_fire, rd_fire, wr_ctrl, wr_tctl, wr_stat;
	logic sp_trail;

	// ----------------------------------------
	// source synchronisation and selection
	// ----------------------------------------
	tgc_sync #(.WIDTH(4)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d_in(src_in),
		.q_out(src_s)
	);
	always_comb begin
		unique case (cfg_r.gate_source_sel)
			`TGC_SS_PIN: sel_raw = src_s.gate_pin;
			`TGC_SS_PERIOD: sel_raw = src_s.period_timer_match;
			`TGC_SS_CMP1: sel_raw = src_s.comparator_one_out;
			`TGC_SS_CMP2: sel_raw = src_s.comparator_two_sync_out;
		endcase
	end
	// polarity applied before edge detect so edges are active-edge edges
	assign pol_out = cfg_r.gate_polarity ? sel_raw : ~sel_raw;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_r <= 1'b0;
			sel_d_r <= 1'b0;
			tog_d_r <= 1'b0;
			lvl_d_r <= 1'b0;
		end else begin
			sel_r <= pol_out;
			sel_d_r <= sel_r;
			tog_d_r <= tog_out;
			lvl_d_r <= gate_level;
		end
	end
	assign sel_rise = sel_r & ~sel_d_r;
	assign sel_fall = ~sel_r & sel_d_r;
	// ----------------------------------------
	// toggle flip-flop
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tog_r <= 1'b0;
		end else if (!cfg_r.gate_toggle_mode || !timer_on_r) begin
			tog_r <= 1'b0;
		end else if (sel_rise) begin
			tog_r <= ~tog_r;
		end
	end
	assign tog_out = cfg_r.gate_toggle_mode ? tog_r : sel_r;
	// ----------------------------------------
	// single pulse acquisition
	// ----------------------------------------
	// trailing edge of whichever gate feeds it; with toggle on this is a
	// full source period, which gives period measurement
	assign sp_trail = ~tog_out & tog_d_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sp_r <= TGC_SP_IDLE;
		end else if (!cfg_r.single_pulse_mode || !go_r) begin
			sp_r <= TGC_SP_IDLE;
		end else begin
			unique case (sp_r)
				TGC_SP_IDLE: sp_r <= tog_out ? TGC_SP_IDLE : TGC_SP_ARMED;
				TGC_SP_ARMED: if (tog_out) begin
					sp_r <= TGC_SP_PULSE;
				end
				TGC_SP_PULSE: if (sp_trail) begin
					sp_r <= TGC_SP_IDLE;
				end
				default: sp_r <= TGC_SP_IDLE;
			endcase
		end
	end
	// a pulse already high at arming is skipped; only a fresh edge counts
	assign gate_level = cfg_r.single_pulse_mode ?
		(tog_out && go_r && sp_r != TGC_SP_IDLE) : tog_out;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			go_r <= 1'b0;
		end else if (!cfg_r.single_pulse_mode) begin
			go_r <= 1'b0;
		end else if (go_r && sp_r == TGC_SP_PULSE && sp_trail) begin
			go_r <= 1'b0;
		end else if (wr_ctrl && wstrb_r[0] && wdata_r[`TGC_BIT_GO]
			&& wdata_r[`TGC_BIT_SPM]) begin
			go_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// count qualification and event flag
	// ----------------------------------------
	assign count_enable = timer_on_r &&
		(!cfg_r.gate_enable_bit || gate_level);
	assign lvl_fall = ~gate_level & lvl_d_r;
	// set wins over a software clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gif_r <= 1'b0;
		end else if (lvl_fall) begin
			gif_r <= 1'b1;
		end else if (wr_stat && wstrb_r[0] && wdata_r[`TGC_BIT_GIF]) begin
			gif_r <= 1'b0;
		end
	end
	assign gate_event_irq = gif_r & gie_r;
	// ----------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------
	assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
	assign s_axi_wready = !w_got_r && !s_axi_bvalid;
	assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
	assign wr_ctrl = wr_fire && awaddr_r == `TGC_OFF_GATE_CTRL;
	assign wr_tctl = wr_fire && awaddr_r == `TGC_OFF_TIMER_CTRL;
	assign wr_stat = wr_fire && awaddr_r == `TGC_OFF_STATUS;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			awaddr_r <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got_r <= 1'b1;
			awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
		end else if (wr_fire) begin
			aw_got_r <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_r <= 1'b0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got_r <= 1'b1;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_got_r <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TGC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_ctrl || wr_tctl || wr_stat) ?
				`TGC_RESP_OKAY : `TGC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r <= '0;
		end else if (wr_ctrl && wstrb_r[0]) begin
			cfg_r.gate_enable_bit <= wdata_r[`TGC_BIT_GE];
			cfg_r.gate_polarity <= wdata_r[`TGC_BIT_POL];
			cfg_r.gate_toggle_mode <= wdata_r[`TGC_BIT_TM];
			cfg_r.single_pulse_mode <= wdata_r[`TGC_BIT_SPM];
			cfg_r.gate_source_sel <=
				wdata_r[`TGC_BIT_SS_HI:`TGC_BIT_SS_LO];
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_on_r <= 1'b0;
			gie_r <= 1'b0;
		end else if (wr_tctl && wstrb_r[0]) begin
			timer_on_r <= wdata_r[`TGC_BIT_ON];
			gie_r <= wdata_r[`TGC_BIT_GIE];
		end
	end

	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	logic [7:0] ctrl_view;
	assign ctrl_view = {cfg_r.gate_enable_bit, cfg_r.gate_polarity,
		cfg_r.gate_toggle_mode, cfg_r.single_pulse_mode, go_r,
		gate_level, cfg_r.gate_source_sel};
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `TGC_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `TGC_RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				`TGC_OFF_GATE_CTRL: s_axi_rdata <= {24'h00_0000, ctrl_view};
				`TGC_OFF_TIMER_CTRL:
					s_axi_rdata <= {30'h0000_0000, gie_r, timer_on_r};
				`TGC_OFF_STATUS: s_axi_rdata <= {31'h0000_0000, gif_r};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `TGC_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb_asrt @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_off_no_count;
		!timer_on_r |-> !count_enable;
	endproperty
	a_off_no_count: assert property (p_off_no_count)
		else $error("count enabled while timer off");
	property p_ungated;
		timer_on_r && !cfg_r.gate_enable_bit |-> count_enable;
	endproperty
	a_ungated: assert property (p_ungated)
		else $error("ungated timer not counting");
	property p_gated;
		timer_on_r && cfg_r.gate_enable_bit |-> count_enable == gate_level;
	endproperty
	a_gated: assert property (p_gated)
		else $error("gated count differs from gate level");
	property p_tog_clear;
		!cfg_r.gate_toggle_mode |=> !tog_r;
	endproperty
	a_tog_clear: assert property (p_tog_clear)
		else $error("toggle flop not cleared");
	property p_tog_flip;
		cfg_r.gate_toggle_mode && timer_on_r && sel_rise
		|=> tog_r != $past(tog_r) || !cfg_r.gate_toggle_mode
			|| !timer_on_r;
	endproperty
	a_tog_flip: assert property (p_tog_flip)
		else $error("toggle flop missed a rising edge");
	property p_spm_clears_go;
		!cfg_r.single_pulse_mode |=> !go_r;
	endproperty
	a_spm_clears_go: assert property (p_spm_clears_go)
		else $error("go bit survived single pulse mode off");
	property p_no_go_no_gate;
		cfg_r.single_pulse_mode && !go_r |-> !gate_level;
	endproperty
	a_no_go_no_gate: assert property (p_no_go_no_gate)
		else $error("gate passed with go clear");
	property p_trail_done;
		go_r && sp_r == TGC_SP_PULSE && sp_trail |=> !go_r;
	endproperty
	a_trail_done: assert property (p_trail_done)
		else $error("go not cleared at trailing edge");
	property p_event_flag;
		$fell(gate_level) |=> gif_r;
	endproperty
	a_event_flag: assert property (p_event_flag)
		else $error("gate event flag not set");
	property p_pol_low;
		!cfg_r.gate_polarity |-> pol_out == !sel_raw;
	endproperty
	a_pol_low: assert property (p_pol_low)
		else $error("polarity inversion wrong");
	c_pulse_done: cover property ($fell(go_r) && cfg_r.single_pulse_mode);
	c_period: cover property (cfg_r.gate_toggle_mode &&
		cfg_r.single_pulse_mode && $fell(go_r));
	c_event: cover property (gate_event_irq);
endmodule
`default_nettype wire

//--- verification/tgc_src_model.sv
/*
 Gate source model: four asynchronous source levels.
 Assumes the bench moves them through drive().
*/
`timescale 1ns/1ps
`default_nettype none
module tgc_src_model (
	output var tgc_pkg::tgc_src_t src_in // raw gate sources
);
	import tgc_pkg::*;
	logic [3:0] lvl;
	initial lvl = 4'h0;
	// called just after a rising edge; pins move by nba like the bus
	task automatic drive(input logic [3:0] v);
		lvl <= v;
	endtask
	// index is the source select code
	assign src_in = {lvl[0], lvl[1], lvl[2], lvl[3]};
endmodule
`default_nettype wire

//--- verification/tgc_gate_test.sv
/*
 Self-checking bench for the timer gate control block.
 Assumes the source model sits beside it; sync delay under 8 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tgc_cfg.svh"
module tgc_gate_test;
	import tgc_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	tgc_src_t src_in;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, count_enable, gate_event_irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [3:0] lv = 4'h0;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	int ge, pol, tm, spm, go, sel, on, gie, gif, tff, sp;
	int pg = 1;
	int gt = 1;
	int glvl = 1;
	always #2 aclk = ~aclk;
	tgc_src_model tgc_src_model_i (.src_in);
	tgc_gate tgc_gate_i (.aclk, .aresetn, .src_in, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.count_enable, .gate_event_irq);
	// ----------------------------------------
	// reporting
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			summarize();
		end
	end
	task automatic bad(input string m);
		n_fail++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) bad($sformatf("data %h exp %h", g, e));
	endtask
	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
		n_checks++;
		if (g !== e) bad($sformatf("resp %b exp %b", g, e));
	endtask
	task automatic chk_pin(input logic g, input logic e, input string n);
		n_checks++;
		if (g !== e) bad($sformatf("%s %b exp %b", n, g, e));
	endtask
	// ----------------------------------------
	// bus master, ready sampled before the edge
	// ----------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ta, tw, tb, aw_ok, w_ok;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		while (!(aw_ok && w_ok)) begin
			@(negedge aclk);
			ta = s_axi_awready && s_axi_awvalid;
			tw = s_axi_wready && s_axi_wvalid;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			aw_ok = aw_ok || ta;
			w_ok = w_ok || tw;
		end
		do begin
			@(negedge aclk);
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
		end while (!tb);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_arready;
			@(posedge aclk);
		end while (!ta);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
		end while (!tr);
		s_axi_rready <= 1'b0;
		chk_data(d, e);
		chk_resp(r, er);
	endtask
	// ----------------------------------------
	// reference model of the gate path
	// ----------------------------------------
	task automatic mstep();
		int s;
		int nl;
		s = lv[sel];
		s = pol ? s : !s;
		if (!tm || !on) tff = 0;
		else if (s && !pg) tff = !tff;
		pg = s;
		gt = tm ? tff : s;
		if (!spm) go = 0;
		if (!go) sp = 0;
		else if (sp == 1 && !gt) sp = 2;
		else if (sp == 2 && gt) sp = 3;
		else if (sp == 3 && !gt) begin
			sp = 0;
			go = 0;
		end
		nl = spm ? (sp == 3 && gt) : gt;
		if (glvl && !nl) gif = 1;
		glvl = nl;
	endtask
	task automatic settle();
		repeat (8) @(posedge aclk);
		@(negedge aclk);
		mstep();
		chk_pin(count_enable, logic'(on && (ge ? glvl : 1)), "cnt");
		chk_pin(gate_event_irq, logic'(gif && gie), "irq");
		rd_chk(`TGC_OFF_GATE_CTRL, {24'h0, ge[0], pol[0], tm[0], spm[0],
			go[0], glvl[0], sel[1:0]}, `TGC_RESP_OKAY);
		rd_chk(`TGC_OFF_STATUS, 32'(gif), `TGC_RESP_OKAY);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk_resp(r, `TGC_RESP_OKAY);
		settle();
	endtask
	task automatic wcfg(input logic [7:0] b);
		if (b[3] && b[4] && !go) begin
			go = 1;
			sp = gt ? 1 : 2;
		end
		ge = b[7];
		pol = b[6];
		tm = b[5];
		spm = b[4];
		sel = b[1:0];
		wreg(`TGC_OFF_GATE_CTRL, {24'h0, b});
	endtask
	task automatic wtim(input logic o, input logic i);
		on = o;
		gie = i;
		wreg(`TGC_OFF_TIMER_CTRL, {30'h0, i, o});
	endtask
	task automatic src_set(input logic [3:0] v);
		lv = v;
		tgc_src_model_i.drive(v);
		settle();
	endtask
	task automatic clr_flag();
		gif = 0;
		wreg(`TGC_OFF_STATUS, 32'h0000_0001);
	endtask
	initial begin
		logic [1:0] r;
		void'($urandom(13));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		settle();
		rd_chk(`TGC_OFF_TIMER_CTRL, 32'h0000_0000, `TGC_RESP_OKAY);
		rd_chk(8'h0c, 32'h0000_0000, `TGC_RESP_SLVERR);
		axi_wr(8'h0c, 32'h0000_00ff, r);
		chk_resp(r, `TGC_RESP_SLVERR);
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			src_set(4'($urandom()));
			wtim(1'($urandom()), 1'($urandom()));
			wcfg({2'($urandom()), 4'h0, 2'($urandom())});
			if (gif) clr_flag();
		end
		$display("test select done");
		wtim(1'b1, 1'b1);
		wcfg(8'he0);
		for (int i = 1; i < 7; i++) src_set({lv[3:1], i[0]});
		wcfg(8'hc0);
		wcfg(8'he0);
		src_set({lv[3:1], 1'b1});
		wtim(1'b0, 1'b1);
		$display("test toggle done");
		wtim(1'b1, 1'b0);
		src_set(4'h0);
		wcfg(8'hd0);
		wcfg(8'hd8);
		for (int i = 1; i < 5; i++) src_set({lv[3:1], i[0]});
		wcfg(8'hd8);
		for (int i = 1; i < 5; i++) src_set({lv[3:1], i[0]});
		wcfg(8'hd8);
		wcfg(8'hc0);
		wcfg(8'hf0);
		wcfg(8'hf8);
		for (int i = 1; i < 7; i++) src_set({lv[3:1], i[0]});
		$display("test single pulse done");
		summarize();
	end
endmodule
`default_nettype wire
